// *** hw/ses_cfg.svh ***
// Constants of the energy-saving sequencer
`ifndef SES_CFG_SVH
`define SES_CFG_SVH

// Clock and times, in ns as specified
`define SES_CLK_NS 25
`define SES_PD_START_NS 1200000
`define SES_SB_WAKE_NS 4000
`define SES_PAUSE_STEP_NS 8000

// Timer width
`define SES_TMR_W 24

// op_state_reg layout
`define SES_SS_BIT 7
`define SES_PD_BIT 6
`define SES_DOS_MSB 2
`define SES_DOS_MEAS 3'h3
`define SES_DOS_CFG 3'h2
`define SES_DOS_NOP 3'h0

// Measurement mode codes
`define SES_MODE_FREE 2'h0
`define SES_MODE_SINGLE 2'h1
`define SES_MODE_EDGE_START 2'h2
`define SES_MODE_EDGE_FRAME 2'h3

// Reset values
`define SES_SS_RESET 1'h0
`define SES_PD_RESET 1'h1
`define SES_SB_RESET 1'h0
`define SES_MODE_RESET 2'h1
`define SES_PAUSE_RESET 8'h00
`define SES_EDGES_RESET 8'h01

`endif

// *** hw/ses_pkg.sv ***
// Types of the energy-saving sequencer
`include "ses_cfg.svh"

package ses_pkg;

    typedef enum logic [2:0] {
        FSM_PDOWN,
        FSM_START_PD,
        FSM_START_SB,
        FSM_IDLE,
        FSM_STANDBY,
        FSM_CONV,
        FSM_PAUSE
    } ses_fsm_type;

    typedef struct packed {
        logic strobe;
        logic [7:0] data;
    } ses_op_wr_type;

    typedef struct packed {
        logic strobe;
        logic standby_bit;
        logic [1:0] mode;
        logic [7:0] pause;
        logic [7:0] edges;
    } ses_cfg_wr_type;

    typedef struct packed {
        ses_fsm_type fsm;
        logic ss;
        logic pd;
        logic meas;
        logic sb;
        logic [1:0] mode;
        logic [7:0] pause;
        logic [7:0] edges;
        logic [7:0] edges_left;
        logic go;
        logic progress_n;
        logic analog_on;
        logic standby_on;
        logic latch;
        logic abort;
        logic [7:0] op_rd;
    } ses_seq_state_type;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic tog;
    } ses_link_state_type;

    typedef struct packed {
        logic tog_s1;
        logic tog_s2;
        logic tog_prev;
        logic pulse;
    } ses_sys_xing_type;

endpackage

// *** hw/ses_timer.sv ***
// Down-counting phase timer
`timescale 1ns/1ps
`include "ses_cfg.svh"

module ses_timer #(
    parameter int W = `SES_TMR_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Counts value cycles, done in the last one
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = value;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == W'(1));

endmodule // ses_timer

// *** hw/ses_trig_xing.sv ***
// Trigger pin falling-edge detect on the link clock, toggle crossing to system clock
`timescale 1ns/1ps

module ses_trig_xing (
    input wire logic link_clk,
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic edge_pulse
);

    ses_pkg::ses_link_state_type lq;
    ses_pkg::ses_link_state_type ld;
    ses_pkg::ses_sys_xing_type sq;
    ses_pkg::ses_sys_xing_type sd;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain
    always_comb begin
        ld = lq;
        ld.rst_s1 = rst_n;
        ld.rst_s2 = lq.rst_s1;
        ld.pin_s1 = pin;
        ld.pin_s2 = lq.pin_s1;
        ld.pin_prev = lq.pin_s2;
        if (lq.pin_prev && !lq.pin_s2) begin
            ld.tog = !lq.tog;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!lq.rst_s2) begin
            lq.rst_s1 <= rst_n;
            lq.rst_s2 <= lq.rst_s1;
            lq.pin_s1 <= 1'h1;
            lq.pin_s2 <= 1'h1;
            lq.pin_prev <= 1'h1;
            lq.tog <= 1'h0;
        end else begin
            lq <= ld;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System domain
    always_comb begin
        sd = sq;
        sd.tog_s1 = lq.tog;
        sd.tog_s2 = sq.tog_s1;
        sd.tog_prev = sq.tog_s2;
        sd.pulse = sq.tog_s2 ^ sq.tog_prev;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sq <= '0;
        end else begin
            sq <= sd;
        end
    end

    assign edge_pulse = sq.pulse;

endmodule // ses_trig_xing

// *** hw/ses_seq_top.sv ***
// Energy-saving sequencer of the light-sensor measurement engine
// Contract
// - Progress output shows the true conversion interval, whatever the delays.
// - Clearing start_stop_bit or config state aborts; partial result not stored.
// - Starting from power-down with standby set: startup time, then wake time.
// - Reset leaves the device powered down, logic idle, host access alive.
// - Host writes accepted in power-down and standby, both operational states.
// - Setting power_down_bit takes effect after a running conversion completes.
// - Clearing power_down_bit moves to idle or standby after startup time.
// - Starts in power-down work in every mode, delayed by startup time.
// - Single and trigger modes return to the chosen saving state; free-running until stopped.
// - Progress output falls once startup is over, marking conversion start.
// - Standby set when starting from power-down adds the wake time.
// - Energy options apply after normal end with latch, or on abort.
// - standby_bit may change only in the configuration state.
// - Standby left on the active mode's start condition, then wake time.
// - With standby_bit set, standby during the pause between conversions.
// - Single-shot end clears start_stop_bit and drops to chosen saving state.
// - Edge-started mode ignores edges during startup, conversion and pause.
// - Trigger pulses ignored in configuration state and during pause.
// - Writing C3h with standby_bit set starts after startup then wake.
// - dev_op_state is bits 2:0; 011b measurement, 000b no operation.
// - Pause is programmable in 8 us steps up to 2040 us.
`timescale 1ns/1ps
`include "ses_cfg.svh"

module ses_seq_top #(
    parameter int unsigned PD_START_CYCLES = (`SES_PD_START_NS + `SES_CLK_NS - 1) / `SES_CLK_NS
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic TRIG_CLK,
    input wire logic TRIGGER_PIN,
    input ses_pkg::ses_op_wr_type OP_WR,
    input ses_pkg::ses_cfg_wr_type CFG_WR,
    input wire logic [`SES_TMR_W-1:0] CONV_CYCLES,
    output logic PROGRESS_N,
    output logic ANALOG_ON,
    output logic STANDBY_ON,
    output logic RESULT_LATCH,
    output logic CONV_ABORT,
    output logic [7:0] OP_STATE_RD,
    output logic STANDBY_BIT_RD
);

    localparam int unsigned SB_WAKE_CYCLES = (`SES_SB_WAKE_NS + `SES_CLK_NS - 1) / `SES_CLK_NS;
    localparam int unsigned PAUSE_STEP_CYCLES = (`SES_PAUSE_STEP_NS + `SES_CLK_NS - 1) / `SES_CLK_NS;

    ses_pkg::ses_seq_state_type q;
    ses_pkg::ses_seq_state_type d;
    ses_pkg::ses_fsm_type rest;
    logic trig;
    logic tdone;
    logic tload;
    logic [`SES_TMR_W-1:0] tval;
    logic start;
    logic run_ok;
    logic internal_mode;
    logic [2:0] dev_op_state;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger pin crossing and phase timer
    ses_trig_xing u_xing (
        .link_clk(TRIG_CLK),
        .sys_clk(SYS_CLK),
        .rst_n(RST_N),
        .pin(TRIGGER_PIN),
        .edge_pulse(trig)
    );

    ses_timer #(
        .W(`SES_TMR_W)
    ) u_timer (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .load(tload),
        .value(tval),
        .done(tdone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        d = q;
        tload = 1'h0;
        tval = `SES_TMR_W'(1);
        d.latch = 1'h0;
        d.abort = 1'h0;
        dev_op_state = OP_WR.data[`SES_DOS_MSB:0];
        internal_mode = (q.mode == `SES_MODE_FREE) || (q.mode == `SES_MODE_SINGLE);
        run_ok = q.ss && q.meas;
        // Trigger edges start a conversion only here; CONV also counts them in edge-frame mode
        start = run_ok && (internal_mode || trig);
        rest = q.pd ? ses_pkg::FSM_PDOWN : (q.sb ? ses_pkg::FSM_STANDBY : ses_pkg::FSM_IDLE);

        unique case (q.fsm)
            ses_pkg::FSM_PDOWN: begin
                if (start) begin
                    d.go = 1'h1;
                    d.fsm = ses_pkg::FSM_START_PD;
                end else if (!q.pd) begin
                    d.go = 1'h0;
                    d.fsm = ses_pkg::FSM_START_PD;
                end
            end
            ses_pkg::FSM_START_PD: begin
                if (tdone) begin
                    if (q.go && run_ok) begin
                        d.fsm = q.sb ? ses_pkg::FSM_START_SB : ses_pkg::FSM_CONV;
                    end else begin
                        d.fsm = rest;
                    end
                end
            end
            ses_pkg::FSM_START_SB: begin
                if (tdone) begin
                    d.fsm = (q.go && run_ok) ? ses_pkg::FSM_CONV : rest;
                end
            end
            ses_pkg::FSM_IDLE: begin
                if (start) begin
                    d.fsm = ses_pkg::FSM_CONV;
                end else if (q.pd) begin
                    d.fsm = ses_pkg::FSM_PDOWN;
                end else if (q.sb) begin
                    d.fsm = ses_pkg::FSM_STANDBY;
                end
            end
            ses_pkg::FSM_STANDBY: begin
                if (start) begin
                    d.go = 1'h1;
                    d.fsm = ses_pkg::FSM_START_SB;
                end else if (q.pd) begin
                    d.fsm = ses_pkg::FSM_PDOWN;
                end else if (!q.sb) begin
                    d.fsm = ses_pkg::FSM_IDLE;
                end
            end
            ses_pkg::FSM_CONV: begin
                if (!run_ok) begin
                    d.abort = 1'h1;
                    d.fsm = rest;
                end else if ((q.mode == `SES_MODE_EDGE_FRAME) ? (trig && q.edges_left <= 8'h01) : tdone) begin
                    d.latch = 1'h1;
                    if (q.mode == `SES_MODE_SINGLE) begin
                        d.ss = 1'h0;
                        d.fsm = rest;
                    end else begin
                        d.fsm = ses_pkg::FSM_PAUSE;
                    end
                end else if (q.mode == `SES_MODE_EDGE_FRAME && trig) begin
                    d.edges_left = q.edges_left - 8'h01;
                end
            end
            ses_pkg::FSM_PAUSE: begin
                if (!run_ok) begin
                    d.fsm = rest;
                end else if (tdone) begin
                    if (q.mode == `SES_MODE_FREE) begin
                        d.go = 1'h1;
                        d.fsm = q.pd ? ses_pkg::FSM_START_PD : (q.sb ? ses_pkg::FSM_START_SB : ses_pkg::FSM_CONV);
                    end else begin
                        d.fsm = rest;
                    end
                end
            end
        endcase

        // Phase timer loads on entry
        if (d.fsm != q.fsm) begin
            unique case (d.fsm)
                ses_pkg::FSM_START_PD: begin
                    tload = 1'h1;
                    tval = `SES_TMR_W'(PD_START_CYCLES);
                end
                ses_pkg::FSM_START_SB: begin
                    tload = 1'h1;
                    tval = `SES_TMR_W'(SB_WAKE_CYCLES);
                end
                ses_pkg::FSM_CONV: begin
                    tload = 1'h1;
                    tval = (CONV_CYCLES == '0) ? `SES_TMR_W'(1) : CONV_CYCLES;
                    d.edges_left = (q.edges == 8'h00) ? 8'h01 : q.edges;
                    d.go = 1'h0;
                end
                ses_pkg::FSM_PAUSE: begin
                    tload = 1'h1;
                    tval = (q.pause == 8'h00) ? `SES_TMR_W'(1) :
                        `SES_TMR_W'(q.pause) * `SES_TMR_W'(PAUSE_STEP_CYCLES);
                end
                default: begin
                    tload = 1'h0;
                end
            endcase
        end

        // Host writes after the state update, so a set beats the hardware clear
        if (OP_WR.strobe) begin
            if (dev_op_state == `SES_DOS_MEAS) begin
                d.meas = 1'h1;
            end else if (dev_op_state == `SES_DOS_CFG) begin
                d.meas = 1'h0;
            end
            d.ss = OP_WR.data[`SES_SS_BIT];
            d.pd = OP_WR.data[`SES_PD_BIT];
        end
        if (CFG_WR.strobe && !q.meas) begin
            d.sb = CFG_WR.standby_bit;
            d.mode = CFG_WR.mode;
            d.pause = CFG_WR.pause;
            d.edges = CFG_WR.edges;
        end

        // Registered outputs follow the next state
        d.progress_n = (d.fsm != ses_pkg::FSM_CONV);
        d.analog_on = (d.fsm != ses_pkg::FSM_PDOWN);
        d.standby_on = (d.fsm == ses_pkg::FSM_STANDBY) || (d.fsm == ses_pkg::FSM_PAUSE && d.sb);
        d.op_rd = {d.ss, d.pd, 3'h0, d.meas ? `SES_DOS_MEAS : `SES_DOS_CFG};
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            q.fsm <= ses_pkg::FSM_PDOWN;
            q.ss <= `SES_SS_RESET;
            q.pd <= `SES_PD_RESET;
            q.meas <= 1'h0;
            q.sb <= `SES_SB_RESET;
            q.mode <= `SES_MODE_RESET;
            q.pause <= `SES_PAUSE_RESET;
            q.edges <= `SES_EDGES_RESET;
            q.edges_left <= `SES_EDGES_RESET;
            q.go <= 1'h0;
            q.progress_n <= 1'h1;
            q.analog_on <= 1'h0;
            q.standby_on <= 1'h0;
            q.latch <= 1'h0;
            q.abort <= 1'h0;
            q.op_rd <= {`SES_SS_RESET, `SES_PD_RESET, 3'h0, `SES_DOS_CFG};
        end else begin
            q <= d;
        end
    end

    assign PROGRESS_N = q.progress_n;
    assign ANALOG_ON = q.analog_on;
    assign STANDBY_ON = q.standby_on;
    assign RESULT_LATCH = q.latch;
    assign CONV_ABORT = q.abort;
    assign OP_STATE_RD = q.op_rd;
    assign STANDBY_BIT_RD = q.sb;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [`SES_TMR_W-1:0] phase_q;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            phase_q <= `SES_TMR_W'(1);
        end else if (d.fsm != q.fsm) begin
            phase_q <= `SES_TMR_W'(1);
        end else begin
            phase_q <= phase_q + `SES_TMR_W'(1);
        end
    end

    a_progress_tracks: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $fell(PROGRESS_N) |-> q.fsm == ses_pkg::FSM_CONV && $past(q.fsm) != ses_pkg::FSM_CONV)
        else $error("progress fell outside conversion start");

    a_abort_no_latch: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_CONV && !run_ok) |=> (q.fsm != ses_pkg::FSM_CONV && !RESULT_LATCH && CONV_ABORT))
        else $error("abort stored a result or kept converting");

    a_pd_then_wake: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_START_PD && tdone && q.go && run_ok && q.sb) |=> q.fsm == ses_pkg::FSM_START_SB)
        else $error("wake phase did not follow startup");

    a_reset_pdown: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        $rose(RST_N) |-> (q.fsm == ses_pkg::FSM_PDOWN && !ANALOG_ON && OP_STATE_RD[`SES_PD_BIT]))
        else $error("not powered down after reset");

    a_pd_waits_conv: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_CONV && q.pd && run_ok && !tdone && !trig) |=> q.fsm == ses_pkg::FSM_CONV)
        else $error("power-down cut a running conversion");

    a_startup_len: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ($past(q.fsm) == ses_pkg::FSM_START_PD && q.fsm != ses_pkg::FSM_START_PD)
        |-> $past(phase_q) == `SES_TMR_W'(PD_START_CYCLES))
        else $error("startup phase length wrong");

    a_wake_len: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        ($past(q.fsm) == ses_pkg::FSM_START_SB && q.fsm != ses_pkg::FSM_START_SB)
        |-> $past(phase_q) == `SES_TMR_W'(SB_WAKE_CYCLES))
        else $error("wake phase length wrong");

    a_single_clears_ss: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_CONV && run_ok && tdone && q.mode == `SES_MODE_SINGLE && !OP_WR.strobe)
        |=> (!OP_STATE_RD[`SES_SS_BIT] && RESULT_LATCH ##1 PROGRESS_N))
        else $error("single shot end did not clear start bit");

    a_pause_ignores: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_PAUSE && run_ok && !tdone) |=> q.fsm == ses_pkg::FSM_PAUSE)
        else $error("pause left early");

    a_sb_locked: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.meas && CFG_WR.strobe) |=> $stable(STANDBY_BIT_RD))
        else $error("standby bit changed in measurement state");

    a_pdown_no_conv: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_PDOWN) |=> q.fsm != ses_pkg::FSM_CONV)
        else $error("conversion began without startup");

    a_op_write_lands: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        OP_WR.strobe |=> (OP_STATE_RD[`SES_SS_BIT] == $past(OP_WR.data[`SES_SS_BIT])
            && OP_STATE_RD[`SES_PD_BIT] == $past(OP_WR.data[`SES_PD_BIT])))
        else $error("host write did not land");

    a_nop_keeps_dos: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (OP_WR.strobe && OP_WR.data[`SES_DOS_MSB:0] == `SES_DOS_NOP) |=> $stable(OP_STATE_RD[`SES_DOS_MSB:0]))
        else $error("no-operation code changed the state");

    a_standby_wakes: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_STANDBY && start) |=> q.fsm == ses_pkg::FSM_START_SB)
        else $error("start in standby skipped the wake phase");

    a_pause_standby: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_PAUSE && q.sb) |-> STANDBY_ON)
        else $error("no standby during pause");

    a_single_to_pdown: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_CONV && run_ok && tdone && q.mode == `SES_MODE_SINGLE && q.pd)
        |=> q.fsm == ses_pkg::FSM_PDOWN)
        else $error("single shot did not return to power-down");

    a_edge_start_holds: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_CONV && run_ok && !tdone && q.mode == `SES_MODE_EDGE_START) |=> q.fsm == ses_pkg::FSM_CONV)
        else $error("edge-started conversion cut short");

    a_trig_mode_rests: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (q.fsm == ses_pkg::FSM_PAUSE && run_ok && tdone && q.mode != `SES_MODE_FREE) |=> q.fsm != ses_pkg::FSM_CONV)
        else $error("trigger mode restarted after pause");

endmodule // ses_seq_top

// *** verif/ses_trig_src.sv ***
// Far-side trigger source with a link clock that runs only in a start-up burst and around each pulse
`timescale 1ns/1ps

module ses_trig_src (
    output logic trig_clk,
    output logic trigger_pin
);
    logic run;

    initial begin
        trig_clk = 1'b0;
        trigger_pin = 1'b1;
        run = 1'b1;
        #300;
        run = 1'b0;
    end

    // Clock stops low once the burst is over
    always begin
        #6;
        if (run || trig_clk)
            trig_clk = ~trig_clk;
    end

    // One falling edge per call, pin idles high between calls
    task automatic pulse();
        run = 1'b1;
        repeat (2) @(posedge trig_clk);
        trigger_pin <= 1'b0;
        repeat (4) @(posedge trig_clk);
        trigger_pin <= 1'b1;
        repeat (6) @(posedge trig_clk);
        run = 1'b0;
    endtask
endmodule // ses_trig_src

// *** verif/ses_seq_top_tb.sv ***
// Self-checking bench of the energy-saving sequencer
`timescale 1ns/1ps
`include "ses_cfg.svh"

module ses_seq_top_tb;
    localparam int CONV = 40;
    logic sys_clk;
    logic rst_n;
    logic trig_clk;
    logic trig_pin;
    ses_pkg::ses_op_wr_type op_wr;
    ses_pkg::ses_cfg_wr_type cfg_wr;
    logic progress_n;
    logic analog_on;
    logic standby_on;
    logic result_latch;
    logic conv_abort;
    logic [7:0] op_rd;
    logic sb_rd;
    int miscompares;
    int checked;
    int n_abort;
    int n_latch;
    int n;

    ses_seq_top #(.PD_START_CYCLES(20)) dut (
        .SYS_CLK(sys_clk),
        .RST_N(rst_n),
        .TRIG_CLK(trig_clk),
        .TRIGGER_PIN(trig_pin),
        .OP_WR(op_wr),
        .CFG_WR(cfg_wr),
        .CONV_CYCLES(24'h000028),
        .PROGRESS_N(progress_n),
        .ANALOG_ON(analog_on),
        .STANDBY_ON(standby_on),
        .RESULT_LATCH(result_latch),
        .CONV_ABORT(conv_abort),
        .OP_STATE_RD(op_rd),
        .STANDBY_BIT_RD(sb_rd)
    );

    ses_trig_src src (
        .trig_clk(trig_clk),
        .trigger_pin(trig_pin)
    );

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) begin
        if (conv_abort === 1'b1)
            n_abort++;
        if (result_latch === 1'b1)
            n_latch++;
    end

    ////////////////////////////////////////
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(negedge sys_clk);
    endtask

    task automatic wr_op(input logic [7:0] d);
        op_wr = '{1'b1, d};
        @(negedge sys_clk);
        op_wr.strobe = 1'b0;
    endtask

    task automatic wr_cfg(input logic sb, input logic [1:0] md, input logic [7:0] ps, input logic [7:0] ed);
        cfg_wr = '{1'b1, sb, md, ps, ed};
        @(negedge sys_clk);
        cfg_wr.strobe = 1'b0;
    endtask

    task automatic wait_prog(input logic lvl, input int bound, output int cnt);
        cnt = 0;
        do begin
            @(negedge sys_clk);
            cnt++;
        end while (progress_n !== lvl && cnt < bound);
        if (progress_n !== lvl) begin
            miscompares++;
            $display("MISMATCH %0t progress wait ran out", $time);
            close_out();
        end
    endtask

    task automatic hold_high(input int c);
        logic ok;
        ok = 1'b1;
        repeat (c) begin
            @(negedge sys_clk);
            if (progress_n !== 1'b1)
                ok = 1'b0;
        end
        chk(ok, 1'b1);
    endtask

    ////////////////////////////////////////
    task automatic sc_reset();
        chk(op_rd, 8'h42);
        chk(analog_on, 1'b0);
        chk(progress_n, 1'b1);
        chk(sb_rd, 1'b0);
    endtask

    task automatic sc_first_start();
        wr_op(8'h02);
        cyc(30);
        chk(op_rd, 8'h02);
        chk(analog_on, 1'b1);
        chk(progress_n, 1'b1);
        wr_op(8'h03);
        cyc(1);
        wr_op(8'h80);
        wait_prog(1'b0, 10, n);
        chk(8'(n), 8'h01);
        wait_prog(1'b1, 60, n);
        chk(8'(n), 8'(CONV));
        chk(result_latch, 1'b1);
        chk(op_rd, 8'h03);
    endtask

    task automatic sc_abort();
        int latches;
        wr_op(8'h83);
        wait_prog(1'b0, 10, n);
        latches = n_latch;
        cyc(5);
        wr_op(8'h03);
        cyc(5);
        chk(8'(n_abort), 8'h01);
        chk(8'(n_latch - latches), 8'h00);
        chk(progress_n, 1'b1);
        chk(op_rd, 8'h03);
    endtask

    task automatic sc_pd_standby();
        wr_op(8'h02);
        wr_cfg(1'b1, `SES_MODE_SINGLE, 8'h00, 8'h01);
        wr_op(8'h03);
        wr_cfg(1'b0, `SES_MODE_SINGLE, 8'h00, 8'h01);
        cyc(2);
        chk(sb_rd, 1'b1);
        wr_op(8'h43);
        cyc(5);
        chk(analog_on, 1'b0);
        wr_op(8'hc3);
        wait_prog(1'b0, 300, n);
        chk(n >= 180 && n <= 186, 1'b1);
        wait_prog(1'b1, 60, n);
        chk(result_latch, 1'b1);
        chk(op_rd, 8'h43);
        cyc(3);
        chk(analog_on, 1'b0);
    endtask

    task automatic sc_free_run();
        wr_op(8'h02);
        cyc(30);
        chk(standby_on, 1'b1);
        wr_cfg(1'b1, `SES_MODE_FREE, 8'h01, 8'h01);
        wr_op(8'h83);
        wait_prog(1'b0, 200, n);
        chk(n >= 160 && n <= 166, 1'b1);
        wait_prog(1'b1, 60, n);
        cyc(5);
        chk(standby_on, 1'b1);
        wait_prog(1'b0, 600, n);
        chk(n >= 470 && n <= 495, 1'b1);
        cyc(5);
        wr_op(8'hc3);
        chk(analog_on, 1'b1);
        wait_prog(1'b1, 60, n);
        chk(8'(n), 8'(CONV - 6));
        chk(result_latch, 1'b1);
        wr_op(8'h43);
        cyc(5);
        chk(analog_on, 1'b0);
        chk(op_rd, 8'h43);
    endtask

    task automatic sc_edge_start();
        wr_op(8'h02);
        wr_cfg(1'b0, `SES_MODE_EDGE_START, 8'h01, 8'h01);
        cyc(30);
        src.pulse();
        hold_high(30);
        wr_op(8'h83);
        cyc(3);
        src.pulse();
        wait_prog(1'b0, 30, n);
        chk(progress_n, 1'b0);
        src.pulse();
        wait_prog(1'b1, 60, n);
        chk(result_latch, 1'b1);
        cyc(290);
        src.pulse();
        hold_high(60);
        src.pulse();
        wait_prog(1'b0, 30, n);
        chk(progress_n, 1'b0);
        wait_prog(1'b1, 60, n);
    endtask

    task automatic sc_edge_frame();
        wr_op(8'h02);
        wr_cfg(1'b0, `SES_MODE_EDGE_FRAME, 8'h00, 8'h02);
        wr_op(8'h83);
        cyc(3);
        src.pulse();
        wait_prog(1'b0, 30, n);
        src.pulse();
        cyc(4);
        chk(progress_n, 1'b0);
        src.pulse();
        wait_prog(1'b1, 30, n);
        chk(result_latch, 1'b1);
    endtask

    initial begin
        rst_n = 1'b0;
        op_wr = '0;
        cfg_wr = '0;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        sc_reset();
        sc_first_start();
        sc_abort();
        sc_pd_standby();
        sc_free_run();
        sc_edge_start();
        sc_edge_frame();
        close_out();
    end
endmodule // ses_seq_top_tb
